/* cmc_pkg.sv */
// Purpose: constants for one comparator channel's control and output conditioning
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
// Behaviour
// [R1] channel disabled: no triggers and no interrupt flags are produced
// [R2] software writes all settings first, then sets the channel enable
// [R3] non-inverted output is high when plus input exceeds minus input
// [R4] amplifier mode when mode bit 10 clear; bit 11 drives amplifier onto pin; code raises amplifier_mode_select_o when bit 10 is set
// [R5] three mask inputs, each picked by its own 4-bit source select
// [R6] and-or network over mask inputs forms blanking that ignores comparator output
// [R7] blanking inactive after reset
// [R8] level sense 0: blanking blocks a high output
// [R9] level sense 1: blanking blocks a low output
// [R10] filter output changes only after three equal consecutive samples, both directions
// [R11] software keeps filter clock period within a third of response time
// [R12] filter active only with filter enable bit 3 set, otherwise bypassed
// [R13] filter bits 2:0 select sampling clock divide ratio
// [R14] filter bits 6:4 select filter divider clock source
// [R15] filter disabled and bypassed after reset
// [R16] invert bit 13 inverts comparator output
// [R17] software changes invert bit only while channel disabled
// [R18] enable and invert may be set together in one write
// [R19] 2-bit edge select picks event edge, independent of pin polarity, needs enable; code takes the edge after invert bit 13
// [R20] bit 4 selects plus input source
// [R21] bits 1:0 select minus input source
// [R22] low power bit 12: 0 standard, 1 low power; not changed while enabled
// [R23] divide codes 000 to 111 give 1:1 doubling up to 1:128
// [R24] source 000 peripheral clock, 001 oscillator, 010-011 pwm sync, 100-111 timers
// [R25] set event flag blocks further events until cleared, plus one rearm cycle
// [R26] shared flag sets when output differs from last read value; read updates it
// [R27] comparator output passes a two-stage synchroniser first
package cmc_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MSRC   = 8'h04;
  localparam logic [7:0] ADDR_MGATE  = 8'h08;
  localparam logic [7:0] ADDR_FILT   = 8'h0c;
  localparam logic [7:0] ADDR_STAT   = 8'h10;
  // channel_control_reg
  localparam int B_EN     = 15;
  localparam int B_INV    = 13;
  localparam int B_LP     = 12;
  localparam int B_PIN    = 11;
  localparam int B_AMPM   = 10;
  localparam int B_EVF    = 9;
  localparam int B_OUT    = 8;
  localparam int B_EDGE   = 6;
  localparam int B_PLUS   = 4;
  localparam int B_MINUS  = 0;
  // mask_source_reg, mask_gating_reg
  localparam int B_SRCA   = 0;
  localparam int B_SRCB   = 4;
  localparam int B_SRCC   = 8;
  localparam int B_ANDEN  = 0;
  localparam int B_OREN   = 8;
  localparam int B_MASK_LEVEL_SENSE   = 15;
  // filter_control_reg
  localparam int B_FDIV   = 0;
  localparam int B_FEN    = 3;
  localparam int B_FSRC   = 4;
  // summary_state_reg
  localparam int B_SIRQ   = 0;
  localparam int B_SEVF   = 1;
  localparam int B_SOUT   = 2;
  // event edge codes and peripheral filter source code
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [2:0] FSRC_PERIPH = 3'h0;
endpackage : cmc_pkg

/* cmc_channel.sv */
// Purpose: apb-controlled digital side of one comparator / amplifier channel
// Assumes: filter clock sources arrive as levels synchronous to mclk_i
// Notes:   zero-wait apb; answer comes one cycle after setup
`timescale 1ns/1ps
`default_nettype none
module cmc_channel
  import cmc_pkg::*;
#(
  parameter int NSRC = 16
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // apb
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // analog side
  input  wire logic             cmp_raw_i,
  input  wire logic [NSRC-1:0]  mask_src_i,
  input  wire logic [7:0]       filter_clock_source_i,
  output logic                  channel_enable_o,
  output logic                  plus_input_select_o,
  output logic      [1:0]       minus_input_select_o,
  output logic                  amplifier_mode_select_o,
  output logic                  amplifier_pin_drive_o,
  output logic                  low_power_select_o,
  // conditioned output and events
  output logic                  output_state_bit_o,
  output logic                  trigger_o,
  output logic                  shared_irq_flag_o
);
  typedef struct packed {
    logic        en;
    logic        inv;
    logic        lp;
    logic        pin;
    logic        ampm;
    logic        evf;
    logic [1:0]  edge_sel;
    logic        plus;
    logic [1:0]  minus;
    logic [3:0]  srca;
    logic [3:0]  srcb;
    logic [3:0]  srcc;
    logic [5:0]  and_en;
    logic [5:0]  or_en;
    logic        mask_level_sense;
    logic        fen;
    logic [2:0]  fsrc;
    logic [2:0]  fdiv;
    logic        sync1;
    logic        sync2;
    logic [7:0]  src_q;
    logic [7:0]  divcnt;
    logic [2:0]  samp;
    logic        filt;
    logic        outst;
    logic        last_rd;
    logic        irq;
    logic        rearm;
    logic        trig;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } cmc_state_s;

  cmc_state_s state_reg;
  cmc_state_s state_next;

  logic        pol;
  logic        ma;
  logic        mb;
  logic        mc;
  logic [5:0]  terms;
  logic        blank;
  logic        masked;
  logic        tick;
  logic [7:0]  div_lim;
  logic        fout;
  logic        rise;
  logic        fall;
  logic        hit;
  logic        setup;
  logic        acc;
  logic [31:0] rd;
  logic        hit_addr;

  always_comb begin
    state_next       = state_reg;
    state_next.trig  = 1'b0;
    state_next.rdy   = 1'b0;
    state_next.err   = 1'b0;
    state_next.rearm = 1'b0;
    // only sync2 reads sync1
    state_next.sync1 = cmp_raw_i; // [R27]
    state_next.sync2 = state_reg.sync1; // [R27]
    pol = state_reg.sync2 ^ state_reg.inv; // [R3] [R16]
    ma  = mask_src_i[state_reg.srca]; // [R5]
    mb  = mask_src_i[state_reg.srcb]; // [R5]
    mc  = mask_src_i[state_reg.srcc]; // [R5]
    terms = {~mc, mc, ~mb, mb, ~ma, ma};
    // all enables zero after reset, so no blanking until configured
    blank = (|(terms & state_reg.or_en)) |
            ((|state_reg.and_en) & (&(terms | ~state_reg.and_en))); // [R6] [R7]
    masked = blank ? state_reg.mask_level_sense : pol; // [R8] [R9]
    // filter sample clock: chosen source edge, then power-of-two divider
    state_next.src_q = filter_clock_source_i;
    if (state_reg.fsrc == FSRC_PERIPH) begin
      tick = 1'b1; // [R24]
    end else begin
      tick = filter_clock_source_i[state_reg.fsrc] & ~state_reg.src_q[state_reg.fsrc]; // [R14] [R24]
    end
    div_lim = 8'((9'h1 << state_reg.fdiv) - 9'h1); // [R13] [R23]
    if (tick) begin
      if (state_reg.divcnt >= div_lim) begin
        state_next.divcnt = 8'h00;
        state_next.samp   = {state_reg.samp[1:0], masked};
      end else begin
        state_next.divcnt = 8'(state_reg.divcnt + 8'h01);
      end
    end
    if (&state_next.samp) begin
      state_next.filt = 1'b1; // [R10]
    end else if (~|state_next.samp) begin
      state_next.filt = 1'b0; // [R10]
    end
    fout = state_reg.fen ? state_reg.filt : masked; // [R12] [R15]
    state_next.outst = state_reg.en & fout; // [R1]
    rise = state_next.outst & ~state_reg.outst;
    fall = ~state_next.outst & state_reg.outst;
    hit  = state_reg.en & ~state_reg.evf & ~state_reg.rearm &
           (((state_reg.edge_sel & EDGE_RISE) != 2'h0 && rise) ||
            ((state_reg.edge_sel & EDGE_FALL) != 2'h0 && fall)); // [R19] [R25] [R1]
    // apb read mux
    rd       = 32'h0;
    hit_addr = 1'b1;
    case (paddr_i)
      ADDR_CTRL: begin
        rd[B_EN]   = state_reg.en;
        rd[B_INV]  = state_reg.inv;
        rd[B_LP]   = state_reg.lp;
        rd[B_PIN]  = state_reg.pin;
        rd[B_AMPM] = state_reg.ampm;
        rd[B_EVF]  = state_reg.evf;
        rd[B_OUT]  = state_reg.outst;
        rd[B_EDGE +: 2]  = state_reg.edge_sel;
        rd[B_PLUS]       = state_reg.plus;
        rd[B_MINUS +: 2] = state_reg.minus;
      end
      ADDR_MSRC: begin
        rd[B_SRCA +: 4] = state_reg.srca;
        rd[B_SRCB +: 4] = state_reg.srcb;
        rd[B_SRCC +: 4] = state_reg.srcc;
      end
      ADDR_MGATE: begin
        rd[B_ANDEN +: 6] = state_reg.and_en;
        rd[B_OREN +: 6]  = state_reg.or_en;
        rd[B_MASK_LEVEL_SENSE]       = state_reg.mask_level_sense;
      end
      ADDR_FILT: begin
        rd[B_FDIV +: 3] = state_reg.fdiv;
        rd[B_FEN]       = state_reg.fen;
        rd[B_FSRC +: 3] = state_reg.fsrc;
      end
      ADDR_STAT: begin
        rd[B_SIRQ] = state_reg.irq;
        rd[B_SEVF] = state_reg.evf;
        rd[B_SOUT] = state_reg.outst;
      end
      default: begin
        hit_addr = 1'b0;
      end
    endcase
    setup = psel_i & ~penable_i;
    acc   = psel_i & penable_i & state_reg.rdy;
    if (setup) begin
      state_next.rdy   = 1'b1;
      state_next.err   = ~hit_addr;
      state_next.rdata = pwrite_i ? 32'h0 : rd;
    end
    if (acc && hit_addr && pwrite_i) begin
      case (paddr_i)
        ADDR_CTRL: begin
          // enable and invert land in the same write
          state_next.en   = pwdata_i[B_EN]; // [R18]
          state_next.inv  = pwdata_i[B_INV]; // [R16] [R18]
          state_next.lp   = pwdata_i[B_LP]; // [R22]
          state_next.pin  = pwdata_i[B_PIN]; // [R4]
          state_next.ampm = pwdata_i[B_AMPM]; // [R4]
          state_next.edge_sel = pwdata_i[B_EDGE +: 2]; // [R19]
          state_next.plus     = pwdata_i[B_PLUS]; // [R20]
          state_next.minus    = pwdata_i[B_MINUS +: 2]; // [R21]
          state_next.evf      = pwdata_i[B_EVF];
          // a cleared flag stays blocked one more cycle
          state_next.rearm    = state_reg.evf & ~pwdata_i[B_EVF]; // [R25]
        end
        ADDR_MSRC: begin
          state_next.srca = pwdata_i[B_SRCA +: 4]; // [R5]
          state_next.srcb = pwdata_i[B_SRCB +: 4]; // [R5]
          state_next.srcc = pwdata_i[B_SRCC +: 4]; // [R5]
        end
        ADDR_MGATE: begin
          state_next.and_en = pwdata_i[B_ANDEN +: 6]; // [R6]
          state_next.or_en  = pwdata_i[B_OREN +: 6]; // [R6]
          state_next.mask_level_sense   = pwdata_i[B_MASK_LEVEL_SENSE]; // [R8] [R9]
        end
        ADDR_FILT: begin
          state_next.fdiv = pwdata_i[B_FDIV +: 3]; // [R13]
          state_next.fen  = pwdata_i[B_FEN]; // [R12]
          state_next.fsrc = pwdata_i[B_FSRC +: 3]; // [R14]
        end
        ADDR_STAT: begin
          // writing 0 clears, 1 leaves the flag alone
          state_next.irq = state_reg.irq & pwdata_i[B_SIRQ];
        end
        default: begin
          state_next.err = 1'b0;
        end
      endcase
    end
    // reading the control register refreshes the compare value; a status register read does not
    if (acc && !pwrite_i && paddr_i == ADDR_CTRL) begin
      state_next.last_rd = state_reg.outst; // [R26]
    end
    // hardware sets win over software clears
    if (hit) begin
      state_next.evf  = 1'b1; // [R25]
      state_next.trig = 1'b1; // [R19]
    end
    if (state_reg.en && state_reg.outst != state_reg.last_rd) begin
      state_next.irq = 1'b1; // [R26] [R1]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0; // [R7] [R15]
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata_o                = state_reg.rdata;
  assign pready_o                = state_reg.rdy;
  assign pslverr_o               = state_reg.err;
  assign channel_enable_o        = state_reg.en;
  assign plus_input_select_o     = state_reg.plus;
  assign minus_input_select_o    = state_reg.minus;
  assign amplifier_mode_select_o = state_reg.ampm;
  assign amplifier_pin_drive_o   = state_reg.pin;
  assign low_power_select_o      = state_reg.lp;
  assign output_state_bit_o      = state_reg.outst;
  assign trigger_o               = state_reg.trig;
  assign shared_irq_flag_o       = state_reg.irq;
endmodule : cmc_channel
`default_nettype wire

/* cmc_channel_assertions.sv */
// Purpose: port checks for cmc_channel
// Assumes: wait-free apb, registered outputs
// Notes:   bind at the foot
`timescale 1ns/1ps
`default_nettype none
module cmc_channel_assertions
  import cmc_pkg::*;
(
  // clock, reset, apb
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // channel
  input wire logic        channel_enable_o,
  input wire logic        amplifier_mode_select_o,
  input wire logic        amplifier_pin_drive_o,
  input wire logic        output_state_bit_o,
  input wire logic        trigger_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic wr_ctrl;
  assign wr_ctrl = psel_i && penable_i && pwrite_i && paddr_i == ADDR_CTRL;
  chk_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_err_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("bad error answer");
  chk_off_no_trig: assert property (!channel_enable_o && !$past(channel_enable_o) |-> !trigger_o)
    else $error("trigger while off");
  chk_off_out_low: assert property (!channel_enable_o ##1 !channel_enable_o |-> !output_state_bit_o)
    else $error("output while off");
  chk_en_write: assert property (wr_ctrl |=> channel_enable_o == $past(pwdata_i[B_EN]))
    else $error("enable not taken");
  chk_amp_bits: assert property (wr_ctrl |=> amplifier_mode_select_o == $past(pwdata_i[B_AMPM])
    && amplifier_pin_drive_o == $past(pwdata_i[B_PIN]))
    else $error("amplifier bits wrong");
  chk_trig_edge: assert property (trigger_o |-> output_state_bit_o != $past(output_state_bit_o))
    else $error("trigger without edge");
  chk_trig_block: assert property (trigger_o |=> !trigger_o [*2])
    else $error("event not blocked");
endmodule : cmc_channel_assertions
bind cmc_channel cmc_channel_assertions u_chk (.*);
`default_nettype wire

/* cmc_analog_model.sv */
// Purpose: comparator stage and mask sources
// Assumes: bench commands the result as a level
// Notes:   filter clock sources are counter bits
`timescale 1ns/1ps
`default_nettype none
module cmc_analog_model (
  // commands
  input  wire logic        mclk_i,
  input  wire logic        plus_gt_minus_i,
  input  wire logic [15:0] mask_lvl_i,
  // channel side
  output logic             cmp_raw_o,
  output logic      [15:0] mask_src_o,
  output logic      [7:0]  fclk_o
);
  logic [7:0] cnt = 8'h00;
  always @(posedge mclk_i) cnt <= cnt + 8'h01;
  // response lag keeps the result off the edge
  assign #1 cmp_raw_o = plus_gt_minus_i;
  assign mask_src_o = mask_lvl_i;
  assign fclk_o = cnt;
endmodule : cmc_analog_model
`default_nettype wire

/* cmc_channel_tb.sv */
// Purpose: self-checking bench for cmc_channel
// Assumes: read answers checked from a queue
// Notes:   xorshift seeded 71
`timescale 1ns/1ps
`default_nettype none
module cmc_channel_tb;
  import cmc_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        lvl = 1'b0;
  logic [15:0] mlvl = 16'h0;
  logic [31:0] seed = 32'h47;
  logic [31:0] c, prdata_o;
  logic        pready_o, pslverr_o, cmp_raw_i, channel_enable_o, plus_input_select_o;
  logic        amplifier_mode_select_o, amplifier_pin_drive_o, low_power_select_o;
  logic        output_state_bit_o, trigger_o, shared_irq_flag_o;
  logic [1:0]  minus_input_select_o;
  logic [15:0] mask_src_i;
  logic [7:0]  filter_clock_source_i;
  logic [3:0]  sel;
  logic [32:0] q[$];
  int          error_cnt = 0;
  int          checked = 0;
  int          ntrig = 0;
  always #2 mclk_i = ~mclk_i;
  cmc_analog_model u_ana (.mclk_i(mclk_i), .plus_gt_minus_i(lvl), .mask_lvl_i(mlvl),
    .cmp_raw_o(cmp_raw_i), .mask_src_o(mask_src_i), .fclk_o(filter_clock_source_i));
  cmc_channel dut (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n == 20) begin
      error_cnt++;
      end_sim();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic end_sim();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // result monitor: oldest note against each read answer
  always @(posedge mclk_i)
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) chk("rdata", {pslverr_o, prdata_o}, q.pop_front());
  always @(posedge mclk_i) if (trigger_o === 1'b1) ntrig <= ntrig + 1;
  initial begin
    #40000;
    error_cnt++;
    end_sim();
  end
  initial begin
    cyc(3);
    rst_i <= 1'b0;
    rd(ADDR_CTRL, 33'h0);
    rd(ADDR_MGATE, 33'h0);
    rd(ADDR_FILT, 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    c = rnd() & 32'h1c13;
    wr(ADDR_CTRL, c);
    wr(ADDR_CTRL, c | 32'ha000);
    cyc(6);
    chk("cfg", {low_power_select_o, amplifier_pin_drive_o, amplifier_mode_select_o, plus_input_select_o,
      minus_input_select_o}, {c[12:10], c[4], c[1:0]});
    rd(ADDR_CTRL, {1'b0, c | 32'ha100});
    wr(ADDR_STAT, 32'h0);
    cyc(2);
    chk("irq", shared_irq_flag_o, 1'b0);
    lvl <= 1'b1;
    cyc(6);
    chk("irq", shared_irq_flag_o, 1'b1);
    for (int e = 0; e < 4; e++) begin
      ntrig = 0;
      wr(ADDR_CTRL, 32'(e) << 6);
      lvl <= 1'b0;
      cyc(6);
      wr(ADDR_CTRL, 32'h8000 | 32'(e) << 6);
      lvl <= 1'b1;
      cyc(6);
      lvl <= 1'b0;
      cyc(6);
      rd(ADDR_CTRL, {1'b0, 32'h8000 | 32'(e) << 6 | 32'(e != 0) << 9});
      wr(ADDR_CTRL, 32'h8000 | 32'(e) << 6);
      cyc(3);
      lvl <= 1'b1;
      cyc(6);
      chk("trig", ntrig, (e != 0) + e[0]);
    end
    c = rnd();
    sel = c[3:0];
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MSRC, 32'(sel));
    wr(ADDR_MGATE, 32'h0100);
    wr(ADDR_CTRL, 32'h8000);
    mlvl <= c[31:16] | 16'h1 << sel;
    cyc(6);
    chk("blank", output_state_bit_o, 1'b0);
    mlvl <= c[31:16] & ~(16'h1 << sel);
    cyc(6);
    chk("pass", output_state_bit_o, 1'b1);
    wr(ADDR_MGATE, 32'h8100);
    mlvl <= c[31:16] | 16'h1 << sel;
    cyc(2);
    lvl <= 1'b0;
    cyc(6);
    chk("blank", output_state_bit_o, 1'b1);
    wr(ADDR_MGATE, 32'h0);
    cyc(6);
    for (int d = 0; d < 3; d++) begin
      wr(ADDR_FILT, 32'h8 | 32'(d));
      lvl <= 1'b1;
      cyc(2 << d);
      lvl <= 1'b0;
      cyc(12 << d);
      chk("glitch", output_state_bit_o, 1'b0);
      lvl <= 1'b1;
      cyc((8 << d) + 4);
      chk("filt", output_state_bit_o, 1'b1);
      lvl <= 1'b0;
      cyc((8 << d) + 4);
    end
    wr(ADDR_FILT, 32'h0);
    lvl <= 1'b1;
    cyc(4);
    chk("bypass", output_state_bit_o, 1'b1);
    end_sim();
  end
endmodule : cmc_channel_tb
`default_nettype wire
